//--- design/asd_setup_regs.svh
`ifndef ASD_SETUP_REGS_SVH
`define ASD_SETUP_REGS_SVH

// Command byte fields
`define ASD_BIT_SELECT_CONV   7
`define ASD_BIT_SELECT_SETUP  6
`define ASD_BIT_CLK_HIGH      5
`define ASD_BIT_CLK_LOW       4
`define ASD_BIT_REF_HIGH      3
`define ASD_BIT_REF_LOW       2
`define ASD_BIT_PAIR_HIGH     1
`define ASD_BIT_PAIR_LOW      0

// Reset values
`define ASD_RST_CLOCK_MODE    2'h2
`define ASD_RST_REF_MODE      2'h2
`define ASD_RST_PAIR_MODE     2'h0

// Reference sequencing delays in conversion clock cycles
`define ASD_WAKE_CYCLES       9'd218
`define ASD_TEMP_SETTLE       9'd244
`define ASD_TEMP_HELD_CYCLES  9'd188

`endif

//--- design/asd_setup_pkg.sv
package asd_setup_pkg;

    typedef enum logic [1:0]
    {
        ASD_PAIR_NONE0 = 2'h0,
        ASD_PAIR_NONE1 = 2'h1,
        ASD_PAIR_UNI   = 2'h2,
        ASD_PAIR_BIP   = 2'h3
    } asd_pair_t;

    typedef enum logic [1:0]
    {
        ASD_IDLE,
        ASD_WAIT,
        ASD_RUN
    } asd_seq_t;

    // Decoded setup outputs
    typedef struct packed
    {
        logic [1:0] clock_mode;
        logic [1:0] ref_mode;
        logic       start_pin_is_input;
        logic       start_timed_acq;
        logic       serial_clocked;
        logic       adc_ref_on_pin;
        logic       uni_write_next;
        logic       bip_write_next;
    } asd_cfg_t;

    // Serial link side state
    typedef struct packed
    {
        logic [2:0] bit_cnt;
        logic [6:0] shift;
        logic [7:0] byte_last;
        logic       byte_tgl;
        logic       data_phase;
        logic       is_setup;
    } asd_link_t;

    // Core side state
    typedef struct packed
    {
        asd_cfg_t   cfg;
        asd_seq_t   seq;
        logic [8:0] wait_cnt;
        logic       iref_on;
        logic       conv_go;
        logic       setup_seen;
        logic       conv_cmd;
        logic [2:0] tgl_sync;
    } asd_core_t;

endpackage : asd_setup_pkg

//--- design/asd_setup_decode.sv
`include "asd_setup_regs.svh"

// Contract
// - MSB 0, bit 6 1 writes setup
// - Clock select high resets to one
// - Clock field picks modes and start pin
// - Mode 01: start pin times acquisition
// - Mode 11: serial clock clocks, max 3.6MHz
// - Bits 1:0 select pairing registers
// - Pairing 10 targets unipolar register next
// - Pairing 11 targets bipolar register next
// - Ref 00: power down, 218 wake cycles
// - Ref 10 default, same power-down behaviour
// - Temperature: reference on, 244 settle cycles
// - Temperature with reference held on: wait 188 cycles
// - Pairing 00/01: no data byte follows
// - MSB 1 selects conversion register
module asd_setup_decode
    import asd_setup_pkg::*;
(
    // Core clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Serial link, its own clock
    input  wire logic       link_clock,
    input  wire logic       link_select_n,
    input  wire logic       link_data_in,
    // Start pin, and scan control from the converter core
    input  wire logic       convert_start_pin,
    input  wire logic       temp_request,
    input  wire logic       ref_held_on,
    input  wire logic       scan_done,
    // Decoded configuration and sequencing
    output asd_cfg_t        cfg,
    output logic            iref_enable,
    output logic            conversion_go,
    output logic            conv_cmd_seen,
    output logic            setup_written
);

    asd_link_t lk_q;
    asd_link_t lk_d;
    asd_core_t cr_q;
    asd_core_t cr_d;

    logic [1:0] start_sync_q;
    logic [1:0] temp_sync_q;
    logic [1:0] held_sync_q;
    logic [1:0] done_sync_q;
    logic       start_prev_q;

    // Link domain: shift command bytes; byte after pairing setup is data
    always_comb
    begin
        lk_d = lk_q;
        if (link_select_n)
        begin
            lk_d.bit_cnt    = 3'h0;
            lk_d.data_phase = 1'b0;
        end
        else
        begin
            lk_d.shift   = {lk_q.shift[5:0], link_data_in};
            lk_d.bit_cnt = lk_q.bit_cnt + 3'h1;
            if (lk_q.bit_cnt == 3'h7)
            begin
                lk_d.byte_last = {lk_q.shift, link_data_in};
                if (!lk_q.data_phase)
                begin
                    lk_d.byte_tgl = ~lk_q.byte_tgl;
                    lk_d.is_setup = !lk_q.shift[6] && lk_q.shift[5];
                    // Data byte only follows pairing codes 10 and 11
                    lk_d.data_phase = !lk_q.shift[6] && lk_q.shift[5]
                                      && lk_q.shift[0];
                end
                else
                begin
                    lk_d.data_phase = 1'b0;
                end
            end
        end
    end

    // Clears only on reset; the link clock may stop between frames
    always_ff @(posedge link_clock or posedge rst)
    begin
        if (rst)
        begin
            lk_q <= '0;
        end
        else
        begin
            lk_q <= lk_d;
        end
    end

    // Pin and core inputs are synchronised before use
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            start_sync_q <= 2'h3;
            temp_sync_q  <= 2'h0;
            held_sync_q  <= 2'h0;
            done_sync_q  <= 2'h0;
            start_prev_q <= 1'b1;
        end
        else
        begin
            start_sync_q <= {start_sync_q[0], convert_start_pin};
            temp_sync_q  <= {temp_sync_q[0], temp_request};
            held_sync_q  <= {held_sync_q[0], ref_held_on};
            done_sync_q  <= {done_sync_q[0], scan_done};
            start_prev_q <= start_sync_q[1];
        end
    end

    logic       new_byte;
    logic       scan_req;
    logic       start_fall;
    logic [7:0] cmd;
    assign new_byte   = cr_q.tgl_sync[2] ^ cr_q.tgl_sync[1];
    assign start_fall = start_prev_q && !start_sync_q[1];
    // Byte is stable: its toggle passed two flops after capture
    assign cmd        = lk_q.byte_last;

    always_comb
    begin
        cr_d            = cr_q;
        cr_d.tgl_sync   = {cr_q.tgl_sync[1:0], lk_q.byte_tgl};
        cr_d.conv_go    = 1'b0;
        cr_d.setup_seen = 1'b0;
        cr_d.conv_cmd   = 1'b0;
        scan_req        = 1'b0;
        if (new_byte)
        begin
            if (cmd[`ASD_BIT_SELECT_CONV])
            begin
                cr_d.conv_cmd = 1'b1;
                if (cr_q.cfg.clock_mode[1])
                begin
                    scan_req = cr_q.seq == ASD_IDLE;
                end
            end
            else if (cmd[`ASD_BIT_SELECT_SETUP])
            begin
                cr_d.setup_seen     = 1'b1;
                cr_d.cfg.clock_mode = cmd[`ASD_BIT_CLK_HIGH:`ASD_BIT_CLK_LOW];
                cr_d.cfg.ref_mode   = cmd[`ASD_BIT_REF_HIGH:`ASD_BIT_REF_LOW];
                cr_d.cfg.uni_write_next = cmd[1:0] == ASD_PAIR_UNI;
                cr_d.cfg.bip_write_next = cmd[1:0] == ASD_PAIR_BIP;
            end
        end
        // Start pin meaning and clocking follow the clock field
        cr_d.cfg.start_pin_is_input = !cr_d.cfg.clock_mode[1];
        cr_d.cfg.start_timed_acq    = cr_d.cfg.clock_mode == 2'h1;
        cr_d.cfg.serial_clocked     = cr_d.cfg.clock_mode == 2'h3;
        cr_d.cfg.adc_ref_on_pin     = cr_d.cfg.ref_mode[0];
        if (start_fall && !cr_q.cfg.clock_mode[1] && cr_q.seq == ASD_IDLE)
        begin
            scan_req = 1'b1;
        end
        unique case (cr_q.seq)
            ASD_IDLE:
            begin
                if (scan_req)
                begin
                    if (temp_sync_q[1])
                    begin
                        cr_d.iref_on  = 1'b1;
                        cr_d.wait_cnt = (held_sync_q[1] || cr_q.iref_on)
                                        ? `ASD_TEMP_HELD_CYCLES
                                        : `ASD_TEMP_SETTLE;
                        cr_d.seq      = ASD_WAIT;
                    end
                    else if (!cr_q.cfg.ref_mode[0])
                    begin
                        cr_d.iref_on  = 1'b1;
                        cr_d.wait_cnt = (cr_q.iref_on || held_sync_q[1])
                                        ? 9'd0 : `ASD_WAKE_CYCLES;
                        cr_d.seq      = ASD_WAIT;
                    end
                    else
                    begin
                        // No internal reference to wait for
                        cr_d.seq     = ASD_RUN;
                        cr_d.conv_go = 1'b1;
                    end
                end
            end
            ASD_WAIT:
            begin
                if (cr_q.wait_cnt == 9'd0)
                begin
                    // Go only once the reference has settled
                    cr_d.seq     = ASD_RUN;
                    cr_d.conv_go = 1'b1;
                end
                else
                begin
                    cr_d.wait_cnt = cr_q.wait_cnt - 9'd1;
                end
            end
            ASD_RUN:
            begin
                if (done_sync_q[1])
                begin
                    cr_d.seq     = ASD_IDLE;
                    // Auto power-down unless held on
                    cr_d.iref_on = held_sync_q[1];
                end
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            cr_q                 <= '0;
            cr_q.cfg.clock_mode  <= `ASD_RST_CLOCK_MODE;
            cr_q.cfg.ref_mode    <= `ASD_RST_REF_MODE;
            cr_q.cfg.start_pin_is_input <= 1'b0;
            cr_q.seq             <= ASD_IDLE;
        end
        else
        begin
            cr_q <= cr_d;
        end
    end

    assign cfg           = cr_q.cfg;
    assign iref_enable   = cr_q.iref_on;
    assign conversion_go = cr_q.conv_go;
    assign conv_cmd_seen = cr_q.conv_cmd;
    assign setup_written = cr_q.setup_seen;

    // Request taken: idle one cycle ago, waiting or running now
    sequence wait_entry_s;
        cr_q.seq == ASD_WAIT && $past(cr_q.seq) == ASD_IDLE;
    endsequence

    sequence run_entry_s;
        cr_q.seq == ASD_RUN && $past(cr_q.seq) == ASD_IDLE;
    endsequence

    sequence pin_start_s;
        start_fall && cr_q.seq == ASD_IDLE && !new_byte;
    endsequence

    sequence last_bit_s;
        !link_select_n && lk_q.bit_cnt == 3'h7;
    endsequence

    wait_exit_a: assert property (@(posedge clock) disable iff (rst)
        cr_q.seq == ASD_WAIT && cr_q.wait_cnt == 9'd0
        |=> cr_q.seq == ASD_RUN && conversion_go)
        else $error("wait did not end");

    wait_ref_on_a: assert property (@(posedge clock) disable iff (rst)
        cr_q.seq == ASD_WAIT |-> iref_enable)
        else $error("reference off while waiting");

    temp_settle_a: assert property (@(posedge clock) disable iff (rst)
        wait_entry_s ##0 ($past(temp_sync_q[1]) && !$past(held_sync_q[1])
        && !$past(cr_q.iref_on)) |-> cr_q.wait_cnt == 9'd244 && cr_q.iref_on)
        else $error("temp settle wrong");

    held_wait_a: assert property (@(posedge clock) disable iff (rst)
        wait_entry_s ##0 ($past(temp_sync_q[1]) && $past(held_sync_q[1]))
        |-> cr_q.wait_cnt == 9'd188)
        else $error("held wait wrong");

    wake_delay_a: assert property (@(posedge clock) disable iff (rst)
        wait_entry_s ##0 (!$past(temp_sync_q[1]) && !$past(held_sync_q[1])
        && !$past(cr_q.iref_on)) |-> cr_q.wait_cnt == 9'd218)
        else $error("wake delay wrong");

    direct_run_a: assert property (@(posedge clock) disable iff (rst)
        run_entry_s |-> conversion_go && $past(cr_q.cfg.ref_mode[0])
        && !$past(temp_sync_q[1]))
        else $error("run without reference check");

    auto_off_a: assert property (@(posedge clock) disable iff (rst)
        cr_q.seq == ASD_RUN && done_sync_q[1]
        |=> cr_q.seq == ASD_IDLE && iref_enable == $past(held_sync_q[1]))
        else $error("reference not powered down");

    pin_go_a: assert property (@(posedge clock) disable iff (rst)
        pin_start_s ##0 !cr_q.cfg.clock_mode[1] |=> cr_q.seq != ASD_IDLE)
        else $error("start pin ignored");

    pin_refuse_a: assert property (@(posedge clock) disable iff (rst)
        pin_start_s ##0 cr_q.cfg.clock_mode[1] |=> cr_q.seq == ASD_IDLE)
        else $error("start pin taken as input");

    setup_decode_a: assert property (@(posedge clock) disable iff (rst)
        new_byte && !cmd[7] && cmd[6] |=> setup_written
        && cfg.clock_mode == $past(cmd[5:4]) && cfg.ref_mode == $past(cmd[3:2]))
        else $error("setup not decoded");

    conv_select_a: assert property (@(posedge clock) disable iff (rst)
        new_byte && cmd[7] |=> conv_cmd_seen && !setup_written)
        else $error("conversion select wrong");

    pair_target_a: assert property (@(posedge clock) disable iff (rst)
        setup_written |-> cfg.uni_write_next == ($past(cmd[1:0]) == 2'h2)
        && cfg.bip_write_next == ($past(cmd[1:0]) == 2'h3))
        else $error("pairing target wrong");

    start_mode_a: assert property (@(posedge clock) disable iff (rst)
        cfg.start_pin_is_input == !cfg.clock_mode[1]
        && cfg.serial_clocked == (cfg.clock_mode == 2'h3))
        else $error("clock mode decode wrong");

    data_byte_a: assert property (@(posedge link_clock) disable iff (rst)
        last_bit_s ##0 lk_q.data_phase
        |=> !lk_q.data_phase && lk_q.byte_tgl == $past(lk_q.byte_tgl))
        else $error("data byte taken as command");

    no_data_a: assert property (@(posedge link_clock) disable iff (rst)
        last_bit_s ##0 (!lk_q.data_phase && !lk_q.shift[0]) |=> !lk_q.data_phase)
        else $error("data byte expected after pairing 0x");

endmodule : asd_setup_decode

//--- test/asd_host_model.sv
module asd_host_model
(
    // Serial link
    output logic link_clock,
    output logic link_select_n,
    output logic link_data_in,
    // Start pin
    output logic convert_start_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    // Link clock stands still between frames
    initial
    begin
        link_clock = 1'b0;
        link_select_n = 1'b1;
        link_data_in = 1'b0;
        convert_start_pin = 1'b1;
    end

    // MSB first; never clocks conversions, so the mode 11 limit is not reached
    task automatic send(input logic [7:0] b);
        #5 link_select_n = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            link_data_in = b[i];
            #24 link_clock = 1'b1;
            #24 link_clock = 1'b0;
        end
        #24 link_select_n = 1'b1;
        // Released line must not look like the last bit
        link_data_in = ~b[0];
    endtask : send

    // Low pulse starts a scan in clock modes 00 and 01; times acquisition only in mode 01
    task automatic pulse;
        convert_start_pin = 1'b0;
        #40 convert_start_pin = 1'b1;
    endtask : pulse
endmodule : asd_host_model

//--- test/adc_setup_command_decode_tb.sv
module adc_setup_command_decode_tb
    import asd_setup_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic     clock = 1'b0;
    logic     rst = 1'b1;
    logic     link_clock, link_select_n, link_data_in, convert_start_pin;
    logic     temp_request = 1'b0;
    logic     ref_held_on = 1'b0;
    logic     scan_done = 1'b0;
    asd_cfg_t cfg;
    logic     iref_enable, conversion_go, conv_cmd_seen, setup_written;
    int       bad_count = 0;
    int       check_count = 0;
    int       cyc = 0;
    int       n_set = 0;
    int       n_cmd = 0;
    int       n_go = 0;
    int       go_cyc = 0;
    int       k;
    int       j;
    int       t_mark = 0;
    int       g_mark = 0;

    // Clocks from stimulus to a taken request: pin path, one link byte
    localparam int PIN_LAT  = 3;
    localparam int LINK_LAT = 49;

    always #4 clock = ~clock;

    asd_host_model i_host (.link_clock(link_clock), .link_select_n(link_select_n),
        .link_data_in(link_data_in), .convert_start_pin(convert_start_pin));

    asd_setup_decode i_dut (.clock(clock), .rst(rst), .link_clock(link_clock),
        .link_select_n(link_select_n), .link_data_in(link_data_in),
        .convert_start_pin(convert_start_pin), .temp_request(temp_request),
        .ref_held_on(ref_held_on), .scan_done(scan_done), .cfg(cfg),
        .iref_enable(iref_enable), .conversion_go(conversion_go),
        .conv_cmd_seen(conv_cmd_seen), .setup_written(setup_written));

    // Pulses stand one cycle, so count them at every edge
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (setup_written === 1'b1)
            n_set <= n_set + 1;
        if (conv_cmd_seen === 1'b1)
            n_cmd <= n_cmd + 1;
        if (conversion_go === 1'b1)
        begin
            n_go <= n_go + 1;
            go_cyc <= cyc;
        end
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    // Whole byte, then room for the 3-4 cycle answer
    task automatic put(input logic [7:0] b);
        i_host.send(b);
        repeat (10) @(negedge clock);
    endtask : put

    function automatic logic [7:0] sb(input logic [1:0] c, input logic [1:0] r,
        input logic [1:0] p);
        return {2'h1, c, r, p};
    endfunction : sb

    // Delay counts from the mark taken just before the stimulus
    task automatic wait_go(input int exp);
        for (k = 0; k < 400 && n_go == g_mark; k++)
            @(negedge clock);
        check("go_delay", 16'(go_cyc - t_mark), 16'(exp));
    endtask : wait_go

    task automatic mark;
        t_mark = cyc;
        g_mark = n_go;
    endtask : mark

    task automatic finish_scan;
        scan_done = 1'b1;
        repeat (4) @(negedge clock);
        scan_done = 1'b0;
        repeat (6) @(negedge clock);
    endtask : finish_scan

    initial
    begin
        repeat (4) @(negedge clock);
        rst = 1'b0;
        repeat (4) @(negedge clock);
        check("clk_reset", cfg.clock_mode, 16'h2);
        check("ref_reset", cfg.ref_mode, 16'h2);
        for (int m = 0; m < 4; m++)
        begin
            k = n_set;
            put(sb(2'(m), 2'(m), 2'h0));
            check("written", 16'(n_set - k), 16'h1);
            check("clock_mode", cfg.clock_mode, 16'(m));
            check("ref_mode", cfg.ref_mode, 16'(m));
            check("pin_input", cfg.start_pin_is_input, 16'(m < 2));
            check("pin_timed", cfg.start_timed_acq, 16'(m == 1));
            check("link_clocked", cfg.serial_clocked, 16'(m == 3));
            check("ref_pin", cfg.adc_ref_on_pin, 16'(m % 2));
            check("pair_none", {cfg.uni_write_next, cfg.bip_write_next}, 16'h0);
        end
        put(sb(2'h2, 2'h2, 2'h2));
        check("uni_next", cfg.uni_write_next, 16'h1);
        k = n_set;
        put(8'h70);
        check("uni_data", 16'(n_set - k), 16'h0);
        check("uni_keep", cfg.clock_mode, 16'h2);
        put(sb(2'h2, 2'h2, 2'h3));
        check("bip_next", cfg.bip_write_next, 16'h1);
        k = n_cmd;
        put(8'h80);
        check("bip_data", 16'(n_cmd - k), 16'h0);
        put(sb(2'h2, 2'h2, 2'h1));
        k = n_set;
        put(sb(2'h0, 2'h0, 2'h0));
        check("no_data", 16'(n_set - k), 16'h1);
        k = n_set;
        j = n_cmd;
        mark();
        put(8'h80);
        check("conv_cmd", 16'(n_cmd - j), 16'h1);
        check("conv_not_setup", 16'(n_set - k), 16'h0);
        check("pin_mode_no_go", 16'(n_go - g_mark), 16'h0);
        mark();
        i_host.pulse();
        wait_go(PIN_LAT + 1 + 218);
        check("iref_on", iref_enable, 16'h1);
        finish_scan();
        check("iref_off", iref_enable, 16'h0);
        put(sb(2'h0, 2'h1, 2'h0));
        mark();
        i_host.pulse();
        wait_go(PIN_LAT);
        check("iref_unused", iref_enable, 16'h0);
        finish_scan();
        put(sb(2'h2, 2'h2, 2'h0));
        mark();
        i_host.send(8'h80);
        wait_go(LINK_LAT + 1 + 218);
        finish_scan();
        check("iref_off_ref10", iref_enable, 16'h0);
        temp_request = 1'b1;
        mark();
        i_host.send(8'h81);
        wait_go(LINK_LAT + 1 + 244);
        check("iref_temp", iref_enable, 16'h1);
        finish_scan();
        ref_held_on = 1'b1;
        mark();
        i_host.send(8'h81);
        wait_go(LINK_LAT + 1 + 188);
        finish_scan();
        check("iref_held", iref_enable, 16'h1);
        print_verdict();
    end

    // Whole run is about two thousand cycles
    initial
    begin
        #200000;
        bad_count++;
        print_verdict();
    end
endmodule : adc_setup_command_decode_tb
